// ==== core/rfm_pkg.sv ====
// Summary of operation
// [R1] RX mode plus start begins listening until stopped
// [R2] host programs channel 0..39 before starting
// [R3] auto-ack active when disable bit is 0
// [R4] matched packet answered with ACK or NACK
// [R5] valid packet stored, length-1 kept, ready flag set
// [R6] packet raises irq only when ready mask set
// [R7] host reads length, payload, then advances pointer
// [R8] reception halts while both FIFO slots full
// [R9] leaving deep sleep sets exit flag in standby
// [R10] average-power one-shot result ready after 12 us
// [R11] burst mode stores power of each packet
// [R12] host unlocks and triggers strength circuit (code has no unlock; a 0-to-1 trigger write starts it when enabled in average mode)
// [R13] source code picks core, rail two, battery
// [R14] threshold codes map to eight voltage levels
// [R15] flag-on-fail picks completion or below-level flagging
// [R16] start bit runs one comparison, result readable
// [R17] host trims VCO bias through test page
// [R18] reset loads VCO trim with 2 Mbps value
// [R19] undefined registers read zero
// [R20] status one bit layout, reset zero
// [R21] status two powerup and autocal bits
// [R22] mask bit one passes status to irq
// [R23] polarity bit selects irq active level
// [R24] strength register mode, enable, result fields
// [R25] irq held while any masked status set
// [R26] status sticky until cleared, set wins
`default_nettype none
package rfm_pkg;
	// register offsets
	localparam logic [6:0] ADDR_STS1    = 7'h00;
	localparam logic [6:0] ADDR_STS2    = 7'h01;
	localparam logic [6:0] ADDR_MSK1    = 7'h02;
	localparam logic [6:0] ADDR_MSK2    = 7'h03;
	localparam logic [6:0] ADDR_CFG     = 7'h04;
	localparam logic [6:0] ADDR_PWR     = 7'h05;
	localparam logic [6:0] ADDR_CHAN    = 7'h07;
	localparam logic [6:0] ADDR_SIG     = 7'h09;
	localparam logic [6:0] ADDR_ACK     = 7'h0B;
	localparam logic [6:0] ADDR_MON     = 7'h10;
	localparam logic [6:0] ADDR_FIFO    = 7'h11;
	localparam logic [6:0] ADDR_RXLEN   = 7'h12;
	localparam logic [6:0] ADDR_RXWIN   = 7'h13;
	localparam logic [6:0] ADDR_TRIG    = 7'h1C;
	localparam logic [6:0] ADDR_VCO     = 7'h30;
	localparam logic [6:0] ADDR_PAGE    = 7'h3F;
	// field positions
	localparam int CFG_POL_BIT   = 7;
	localparam int CFG_START_BIT = 1;
	localparam int CFG_DIR_BIT   = 0;
	localparam int PWR_DEEP_BIT  = 1;
	localparam int SIG_MODE_BIT  = 5;
	localparam int SIG_EN_BIT    = 4;
	localparam int ACK_DIS_BIT   = 4;
	localparam int MON_START_BIT = 6;
	localparam int MON_FAIL_BIT  = 5;
	localparam int MON_RES_BIT   = 7;
	localparam int TRIG_BIT      = 7;
	localparam int FIFO_ADV_BIT  = 0;
	// reset values
	localparam logic [7:0] CFG_RESET    = 8'h01;
	localparam logic [7:0] VCO_2M_RESET = 8'h76;
	localparam logic [7:0] PAGE_TEST    = 8'h01;
	// timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int RSSI_TIME_US  = 12;
	localparam int MON_TIME_US   = 2;
	localparam int WAKE_TIME_US  = 1;
	localparam int RSSI_CYC = (RSSI_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MON_CYC  = (MON_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_CYC = (WAKE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// receive flow states
	typedef enum logic [1:0] {RX_IDLE, RX_LISTEN, RX_ACK, RX_STALL} rfm_rx_state_t;
endpackage : rfm_pkg
`default_nettype wire

// ==== core/rfm_reg_if.sv ====
`default_nettype none
interface rfm_reg_if;
	logic       wr_en;
	logic       rd_en;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport serial_side (output wr_en, output rd_en, output addr, output wdata, input rdata);
	modport core_side (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : rfm_reg_if
`default_nettype wire

// ==== core/rfm_spi_slave.sv ====
`default_nettype none
module rfm_spi_slave (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	// serial pins
	input  wire logic spi_cs_n,
	input  wire logic spi_sck,
	input  wire logic spi_mosi,
	output logic      spi_miso_o,
	output logic      spi_miso_oe,
	// register access
	rfm_reg_if.serial_side bus
);
	logic [2:0] cs_s1_q, cs_s2_q;
	logic       sck_d_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [2:0] bit_q;
	logic       first_q, is_wr_q, rd_pend_q;
	logic       act, rise, fall, byte_done;
	logic [7:0] byte_in;

	// two flops on every pin before use; index 0 cs, 1 sck, 2 mosi
	always_ff @(posedge sys_clk) begin
		cs_s1_q <= {spi_mosi, spi_sck, ~spi_cs_n};
		cs_s2_q <= cs_s1_q;
		sck_d_q <= cs_s2_q[1];
	end

	// edges seen from the synchronised copy only
	assign act       = cs_s2_q[0];
	assign rise      = act && cs_s2_q[1] && !sck_d_q;
	assign fall      = act && !cs_s2_q[1] && sck_d_q;
	assign byte_in   = {shift_q[6:0], cs_s2_q[2]};
	assign byte_done = rise && (bit_q == 3'h7);

	// frame: command byte (bit 7 write, 6:0 address), then data bytes at that same address
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !act) begin
			bit_q     <= 3'h0;
			first_q   <= 1'b1;
			is_wr_q   <= 1'b0;
			bus.wr_en <= 1'b0;
			rd_pend_q <= 1'b0;
			if (!reset_n) begin
				shift_q   <= 8'h00;
				bus.addr  <= 7'h00;
				bus.wdata <= 8'h00;
			end
		end else begin
			bus.wr_en <= byte_done && !first_q && is_wr_q;
			// reads load once, after the command byte: a prefetch per data byte would pop the
			// payload window twice per frame, so a read frame carries one meaningful data byte
			rd_pend_q <= byte_done && first_q && !byte_in[7];
			if (rise) begin
				shift_q <= byte_in;
				bit_q   <= bit_q + 3'h1;
			end
			if (byte_done) begin
				first_q <= 1'b0;
				if (first_q) begin
					is_wr_q  <= byte_in[7];
					bus.addr <= byte_in[6:0];
				end else begin
					bus.wdata <= byte_in;
				end
			end
		end
	end

	// read strobe in the same cycle the new address first appears; rdata decodes combinationally from it
	assign bus.rd_en = rd_pend_q;

	// miso shifts out on falling sck; data loaded well before the next byte's first fall
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			tx_q       <= 8'h00;
			spi_miso_o <= 1'b0;
		end else if (rd_pend_q) begin
			tx_q <= bus.rdata;
		end else if (fall) begin
			spi_miso_o <= tx_q[7];
			tx_q       <= {tx_q[6:0], 1'b0};
		end
	end

	assign spi_miso_oe = act;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	AST_WR_SINGLE_PULSE: assert property (bus.wr_en |=> !bus.wr_en) // [R19]
		else $error("write strobe longer than one cycle");
	AST_NO_DRIVE_IDLE: assert property (!act |-> !spi_miso_oe && !bus.wr_en) // [R19]
		else $error("serial side active without select");
endmodule : rfm_spi_slave
`default_nettype wire

// ==== core/rfm_top.sv ====
`default_nettype none
module rfm_top (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// serial register port
	input  wire logic        spi_cs_n,
	input  wire logic        spi_sck,
	input  wire logic        spi_mosi,
	output logic             spi_miso_o,
	output logic             spi_miso_oe,
	// receive datapath from the modem
	input  wire logic        rf_pkt_done,
	input  wire logic        rf_pkt_addr_match,
	input  wire logic        rf_pkt_crc_ok,
	input  wire logic [4:0]  rf_pkt_len_m1,
	input  wire logic        rf_byte_valid,
	input  wire logic [7:0]  rf_byte,
	input  wire logic [3:0]  rf_burst_power,
	input  wire logic [3:0]  rf_avg_power,
	input  wire logic        rf_ack_sent,
	// other event pulses
	input  wire logic        ev_tx_done,
	input  wire logic        ev_retransmit_limit,
	input  wire logic        ev_pll_unlocked,
	input  wire logic        ev_standby_exit,
	input  wire logic        ev_powerup_done,
	input  wire logic        ev_autocal_done,
	// supply levels in millivolts
	input  wire logic [11:0] core_mv,
	input  wire logic [11:0] rail2_mv,
	input  wire logic [11:0] batt_mv,
	// radio control
	output logic             rf_rx_on,
	output logic             rf_tx_on,
	output logic [5:0]       rf_channel,
	output logic             ack_req,
	output logic             ack_nack,
	output logic [7:0]       vco_bias_trim,
	output logic             deep_sleep,
	output logic             irq_pin
);
	rfm_reg_if bus ();

	rfm_spi_slave u_spi (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.spi_cs_n    (spi_cs_n),
		.spi_sck     (spi_sck),
		.spi_mosi    (spi_mosi),
		.spi_miso_o  (spi_miso_o),
		.spi_miso_oe (spi_miso_oe),
		.bus         (bus.serial_side)
	);

	// threshold code to millivolts
	function automatic logic [11:0] thr_mv(input logic [2:0] code);
		case (code)
			3'h0:    thr_mv = 12'h334; // 0.82 V [R14]
			3'h1:    thr_mv = 12'h398; // 0.92 V
			3'h2:    thr_mv = 12'h460; // 1.12 V
			3'h3:    thr_mv = 12'h4E2; // 1.25 V
			3'h4:    thr_mv = 12'h596; // 1.43 V
			3'h5:    thr_mv = 12'h7D0; // 2.00 V
			3'h6:    thr_mv = 12'h8C0; // 2.24 V
			default: thr_mv = 12'h9BA; // 2.49 V
		endcase
	endfunction : thr_mv

	logic [7:0]  sts1_q, sts2_q, msk1_q, msk2_q, cfg_q, page_q, trig_q, vco_q;
	logic [5:0]  chan_q;
	logic        ack_dis_q, deep_q, sig_mode_q, sig_en_q;
	logic [3:0]  sig_res_q;
	logic [5:0]  mon_cfg_q;
	logic        mon_res_q, mon_busy_q, rssi_busy_q, wake_busy_q;
	logic [11:0] mon_cnt_q, rssi_cnt_q, wake_cnt_q;
	rfm_pkg::rfm_rx_state_t state_q, state_d;
	logic [7:0]  fifo_mem [0:63];
	logic [4:0]  len_q [0:1];
	logic        wr_slot_q, rd_slot_q, ack_req_q, ack_nack_q;
	logic [4:0]  wr_idx_q, rd_idx_q;
	logic [1:0]  cnt_q;

	// write decode
	wire w = bus.wr_en;
	wire [7:0] wd = bus.wdata;
	wire wr_sts1 = w && bus.addr == rfm_pkg::ADDR_STS1;
	wire wr_sts2 = w && bus.addr == rfm_pkg::ADDR_STS2;
	wire wr_pwr  = w && bus.addr == rfm_pkg::ADDR_PWR;
	wire wr_sig  = w && bus.addr == rfm_pkg::ADDR_SIG;
	wire wr_mon  = w && bus.addr == rfm_pkg::ADDR_MON;
	wire wr_trig = w && bus.addr == rfm_pkg::ADDR_TRIG;
	wire wr_vco  = w && bus.addr == rfm_pkg::ADDR_VCO && page_q == rfm_pkg::PAGE_TEST;
	wire advance = w && bus.addr == rfm_pkg::ADDR_FIFO && wd[rfm_pkg::FIFO_ADV_BIT] && cnt_q != 2'h0;
	wire pop     = bus.rd_en && bus.addr == rfm_pkg::ADDR_RXWIN;

	// receive flow decode
	wire run      = cfg_q[rfm_pkg::CFG_START_BIT] && !cfg_q[rfm_pkg::CFG_DIR_BIT]; // [R1]
	wire full     = cnt_q == 2'h2;
	wire listen   = state_q == rfm_pkg::RX_LISTEN;
	wire pkt_ok   = listen && rf_pkt_done && rf_pkt_addr_match && rf_pkt_crc_ok;
	wire pkt_bad  = listen && rf_pkt_done && rf_pkt_addr_match && !rf_pkt_crc_ok;
	wire need_ack = listen && rf_pkt_done && rf_pkt_addr_match && !ack_dis_q; // [R3]
	wire commit   = pkt_ok; // [R5]

	// event sources
	wire [11:0] mon_src = mon_cfg_q[1:0] == 2'h0 ? core_mv :
		mon_cfg_q[1:0] == 2'h1 ? rail2_mv : batt_mv; // [R13]
	wire mon_done  = mon_busy_q && mon_cnt_q == 12'h001;
	wire mon_below = mon_src < thr_mv(mon_cfg_q[4:2]); // [R14]
	wire mon_set   = mon_done && (!mon_cfg_q[rfm_pkg::MON_FAIL_BIT] || mon_below); // [R15]
	wire rssi_done = rssi_busy_q && rssi_cnt_q == 12'h001;
	wire wake_done = wake_busy_q && wake_cnt_q == 12'h001;
	wire [7:0] set1 = {commit, ev_tx_done, ev_retransmit_limit, ev_pll_unlocked,
		pkt_bad, mon_set, ev_standby_exit, wake_done}; // [R20]
	wire [7:0] set2 = {6'h00, ev_powerup_done, ev_autocal_done}; // [R21]

	// status: write one to clear, a simultaneous event wins
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sts1_q <= 8'h00;
			sts2_q <= 8'h00;
		end else begin
			sts1_q <= (sts1_q & ~(wr_sts1 ? wd : 8'h00)) | set1; // [R26]
			sts2_q <= (sts2_q & ~(wr_sts2 ? wd & 8'h03 : 8'h00)) | set2;
		end
	end

	// irq level: any masked pending bit, then polarity
	wire pend = |(sts1_q & msk1_q) || |(sts2_q & msk2_q); // [R22] [R25] [R6]
	assign irq_pin = pend ^ cfg_q[rfm_pkg::CFG_POL_BIT]; // [R23]

	// plain control registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			msk1_q    <= 8'h00;
			msk2_q    <= 8'h00;
			cfg_q     <= rfm_pkg::CFG_RESET;
			chan_q    <= 6'h00;
			ack_dis_q <= 1'b0;
			page_q    <= 8'h00;
			trig_q    <= 8'h00;
			vco_q     <= rfm_pkg::VCO_2M_RESET; // [R18]
			deep_q    <= 1'b0;
		end else if (w) begin
			case (bus.addr)
				rfm_pkg::ADDR_MSK1: msk1_q    <= wd;
				rfm_pkg::ADDR_MSK2: msk2_q    <= wd & 8'h01;
				rfm_pkg::ADDR_CFG:  cfg_q     <= wd & 8'hA7;
				rfm_pkg::ADDR_CHAN: chan_q    <= wd[5:0]; // [R2]
				rfm_pkg::ADDR_ACK:  ack_dis_q <= wd[rfm_pkg::ACK_DIS_BIT];
				rfm_pkg::ADDR_PAGE: page_q    <= wd;
				rfm_pkg::ADDR_TRIG: trig_q    <= wd;
				rfm_pkg::ADDR_PWR:  deep_q    <= wd[rfm_pkg::PWR_DEEP_BIT];
				default:            vco_q     <= wr_vco ? wd : vco_q; // [R17]
			endcase
		end
	end

	// deep sleep exit: flag after the standby settle time
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wake_busy_q <= 1'b0;
			wake_cnt_q  <= 12'h000;
		end else if (wr_pwr && deep_q && !wd[rfm_pkg::PWR_DEEP_BIT]) begin
			wake_busy_q <= 1'b1; // [R9]
			wake_cnt_q  <= 12'(rfm_pkg::WAKE_CYC);
		end else if (wake_busy_q) begin
			wake_busy_q <= !wake_done;
			wake_cnt_q  <= wake_cnt_q - 12'h001;
		end
	end

	// supply monitor: one comparison per start write; restart ignored while busy
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mon_cfg_q  <= 6'h00;
			mon_busy_q <= 1'b0;
			mon_cnt_q  <= 12'h000;
			mon_res_q  <= 1'b0;
		end else if (wr_mon && !mon_busy_q) begin
			mon_cfg_q  <= wd[5:0];
			mon_busy_q <= wd[rfm_pkg::MON_START_BIT]; // [R16]
			mon_cnt_q  <= 12'(rfm_pkg::MON_CYC);
		end else if (mon_busy_q) begin
			mon_busy_q <= !mon_done;
			mon_cnt_q  <= mon_cnt_q - 12'h001;
			mon_res_q  <= mon_done ? mon_below : mon_res_q;
		end
	end

	// signal strength: timed one-shot in average mode, per packet in burst mode
	wire rssi_go = wr_trig && wd[rfm_pkg::TRIG_BIT] && !trig_q[rfm_pkg::TRIG_BIT] && !sig_mode_q && sig_en_q;
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sig_mode_q  <= 1'b0;
			sig_en_q    <= 1'b0;
			sig_res_q   <= 4'h0;
			rssi_busy_q <= 1'b0;
			rssi_cnt_q  <= 12'h000;
		end else begin
			if (wr_sig) begin
				sig_mode_q <= wd[rfm_pkg::SIG_MODE_BIT]; // [R24]
				sig_en_q   <= wd[rfm_pkg::SIG_EN_BIT];
			end
			if (rssi_go) begin
				rssi_busy_q <= 1'b1; // [R12]
				rssi_cnt_q  <= 12'(rfm_pkg::RSSI_CYC);
			end else if (rssi_busy_q) begin
				rssi_busy_q <= !rssi_done;
				rssi_cnt_q  <= rssi_cnt_q - 12'h001;
			end
			if (rssi_done)
				sig_res_q <= rf_avg_power; // [R10]
			else if (sig_mode_q && commit)
				sig_res_q <= rf_burst_power; // [R11]
		end
	end

	// receive state machine; a full FIFO parks it in the stall state
	always_comb begin
		state_d = state_q;
		case (state_q)
			rfm_pkg::RX_IDLE:   if (run) state_d = rfm_pkg::RX_LISTEN;
			rfm_pkg::RX_LISTEN: begin
				if (need_ack) state_d = rfm_pkg::RX_ACK; // [R4]
				else if (!run) state_d = rfm_pkg::RX_IDLE;
				else if (full || commit && cnt_q == 2'h1) state_d = rfm_pkg::RX_STALL; // [R8]
			end
			rfm_pkg::RX_ACK:    if (rf_ack_sent) state_d = !run ? rfm_pkg::RX_IDLE :
				(full ? rfm_pkg::RX_STALL : rfm_pkg::RX_LISTEN);
			rfm_pkg::RX_STALL:  begin
				if (!run) state_d = rfm_pkg::RX_IDLE;
				else if (!full) state_d = rfm_pkg::RX_LISTEN;
			end
			default:            state_d = rfm_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_q    <= rfm_pkg::RX_IDLE;
			ack_req_q  <= 1'b0;
			ack_nack_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			ack_req_q  <= need_ack; // [R4]
			ack_nack_q <= need_ack ? !rf_pkt_crc_ok : ack_nack_q;
		end
	end

	// two-slot payload store; bytes land in the free slot, kept only on a good packet
	always_ff @(posedge sys_clk) begin
		if (listen && rf_byte_valid && !full)
			fifo_mem[{wr_slot_q, wr_idx_q}] <= rf_byte;
		if (commit)
			len_q[wr_slot_q] <= rf_pkt_len_m1; // [R5]
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wr_slot_q <= 1'b0;
			rd_slot_q <= 1'b0;
			wr_idx_q  <= 5'h00;
			rd_idx_q  <= 5'h00;
			cnt_q     <= 2'h0;
		end else begin
			wr_idx_q  <= rf_pkt_done ? 5'h00 : wr_idx_q + 5'(listen && rf_byte_valid && !full);
			wr_slot_q <= wr_slot_q ^ commit;
			rd_slot_q <= rd_slot_q ^ advance; // [R7]
			rd_idx_q  <= advance ? 5'h00 : rd_idx_q + 5'(pop);
			cnt_q     <= cnt_q + 2'(commit) - 2'(advance);
		end
	end

	// read mux; anything unlisted reads zero
	assign bus.rdata =
		bus.addr == rfm_pkg::ADDR_STS1  ? sts1_q :
		bus.addr == rfm_pkg::ADDR_STS2  ? sts2_q :
		bus.addr == rfm_pkg::ADDR_MSK1  ? msk1_q :
		bus.addr == rfm_pkg::ADDR_MSK2  ? msk2_q :
		bus.addr == rfm_pkg::ADDR_CFG   ? cfg_q :
		bus.addr == rfm_pkg::ADDR_PWR   ? {6'h00, deep_q, 1'b0} :
		bus.addr == rfm_pkg::ADDR_CHAN  ? {2'h0, chan_q} :
		bus.addr == rfm_pkg::ADDR_SIG   ? {2'h0, sig_mode_q, sig_en_q, sig_res_q} :
		bus.addr == rfm_pkg::ADDR_ACK   ? {3'h0, ack_dis_q, 4'h0} :
		bus.addr == rfm_pkg::ADDR_MON   ? {mon_res_q, mon_busy_q, mon_cfg_q} :
		bus.addr == rfm_pkg::ADDR_RXLEN ? {3'h0, len_q[rd_slot_q]} :
		bus.addr == rfm_pkg::ADDR_RXWIN ? fifo_mem[{rd_slot_q, rd_idx_q}] :
		bus.addr == rfm_pkg::ADDR_TRIG  ? trig_q :
		bus.addr == rfm_pkg::ADDR_VCO   ? vco_q :
		bus.addr == rfm_pkg::ADDR_PAGE  ? page_q : 8'h00; // [R19]

	assign rf_rx_on      = listen; // [R1]
	assign rf_tx_on      = state_q == rfm_pkg::RX_ACK;
	assign rf_channel    = chan_q;
	assign ack_req       = ack_req_q;
	assign ack_nack      = ack_nack_q;
	assign vco_bias_trim = vco_q;
	assign deep_sleep    = deep_q;

	// helper: cycles spent in one strength measurement
	logic [11:0] rssi_len_q;
	always_ff @(posedge sys_clk) begin
		if (!reset_n || rssi_go) rssi_len_q <= 12'h000;
		else if (rssi_busy_q) rssi_len_q <= rssi_len_q + 12'h001;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_good_pkt;
		commit ##1 sts1_q[7];
	endsequence
	AST_RX_READY_SET: assert property (commit |-> s_good_pkt) // [R5]
		else $error("ready flag not set after good packet");
	AST_STICKY_SET_WINS: assert property (commit && wr_sts1 && wd[7] |=> sts1_q[7]) // [R26]
		else $error("clear beat a simultaneous event");
	AST_IRQ_MASKED: assert property (sts1_q[7] && msk1_q[7] && !cfg_q[7] |-> irq_pin) // [R6]
		else $error("masked ready flag did not raise irq");
	AST_IRQ_BLOCKED: assert property (msk1_q == 8'h00 && msk2_q == 8'h00 |-> irq_pin == cfg_q[7]) // [R22]
		else $error("irq active with all masks clear");
	AST_STALL_WHEN_FULL: assert property (full |-> !rf_rx_on) // [R8]
		else $error("listening with full FIFO");
	AST_ACK_NACK: assert property (need_ack |=> ack_req && rf_tx_on && ack_nack == !$past(rf_pkt_crc_ok)) // [R4]
		else $error("acknowledge wrong or missing");
	AST_NO_AUTO_ACK: assert property (ack_dis_q |=> !ack_req) // [R3]
		else $error("acknowledge sent while disabled");
	AST_RSSI_TIME: assert property ($fell(rssi_busy_q) |-> rssi_len_q == 12'(rfm_pkg::RSSI_CYC)) // [R10]
		else $error("strength measurement time wrong");
	AST_MON_FLAG: assert property (mon_done && !mon_cfg_q[rfm_pkg::MON_FAIL_BIT] |=> sts1_q[2]) // [R15]
		else $error("monitor completion flag missing");
endmodule : rfm_top
`default_nettype wire

// ==== tb/rfm_host_model.sv ====
`default_nettype none
// host side of the serial register port: mode 0 master, one command byte and one data byte per frame
module rfm_host_model (
	// clock
	input  wire logic sys_clk,
	// serial pins
	output var logic  spi_cs_n,
	output var logic  spi_sck,
	output var logic  spi_mosi,
	input  wire logic spi_miso_o,
	input  wire logic spi_miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle bus levels before the first frame
	initial begin
		spi_cs_n = 1'b1;
		spi_sck  = 1'b0;
		spi_mosi = 1'b0;
	end

	// 16 sys_clk per serial bit gives the 64 ns link period; the device only samples our edges
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] sh;
		sh = {cmd, wd};
		rd = 8'h00;
		@(posedge sys_clk);
		spi_cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi <= sh[i];
			repeat (8) @(posedge sys_clk);
			spi_sck <= 1'b1;
			if (i < 8) begin
				rd[i] = spi_miso_o;
			end
			repeat (8) @(posedge sys_clk);
			spi_sck <= 1'b0;
		end
		repeat (8) @(posedge sys_clk);
		spi_cs_n <= 1'b1;
		// released data line must not keep showing the last bit
		spi_mosi <= ~spi_mosi;
		repeat (8) @(posedge sys_clk);
	endtask : xfer
endmodule : rfm_host_model
`default_nettype wire

// ==== tb/rx_flow_monitor_irq_control_tb.sv ====
`default_nettype none
module rx_flow_monitor_irq_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LIMIT = 60000;
	localparam int LVL_MV [8] = '{820, 920, 1120, 1250, 1430, 2000, 2240, 2490};
	// design stimulus and observation
	logic        sys_clk, reset_n, spi_cs_n, spi_sck, spi_mosi, spi_miso_o, spi_miso_oe;
	logic        rf_pkt_done, rf_pkt_addr_match, rf_pkt_crc_ok, rf_byte_valid, rf_ack_sent;
	logic [4:0]  rf_pkt_len_m1;
	logic [7:0]  rf_byte, vco_bias_trim;
	logic [3:0]  rf_burst_power, rf_avg_power;
	logic [5:0]  ev;
	logic [11:0] core_mv, rail2_mv, batt_mv;
	logic        rf_rx_on, rf_tx_on, ack_req, ack_nack, deep_sleep, irq_pin;
	logic [5:0]  rf_channel;
	int          error_cnt, samples_checked, cyc;

	rfm_top rfm_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
		.spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .rf_pkt_done(rf_pkt_done),
		.rf_pkt_addr_match(rf_pkt_addr_match), .rf_pkt_crc_ok(rf_pkt_crc_ok), .rf_pkt_len_m1(rf_pkt_len_m1),
		.rf_byte_valid(rf_byte_valid), .rf_byte(rf_byte), .rf_burst_power(rf_burst_power),
		.rf_avg_power(rf_avg_power), .rf_ack_sent(rf_ack_sent), .ev_tx_done(ev[5]), .ev_retransmit_limit(ev[4]),
		.ev_pll_unlocked(ev[3]), .ev_standby_exit(ev[2]), .ev_powerup_done(ev[1]), .ev_autocal_done(ev[0]),
		.core_mv(core_mv), .rail2_mv(rail2_mv), .batt_mv(batt_mv), .rf_rx_on(rf_rx_on), .rf_tx_on(rf_tx_on),
		.rf_channel(rf_channel), .ack_req(ack_req), .ack_nack(ack_nack), .vco_bias_trim(vco_bias_trim),
		.deep_sleep(deep_sleep), .irq_pin(irq_pin));
	rfm_host_model rfm_host_model_inst (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
		.spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));

	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	// a hung handshake ends the run with a mismatch
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			results();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		rfm_host_model_inst.xfer({1'b1, a}, d, x);
	endtask : wr

	// read and compare only the bits under the mask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] x;
		rfm_host_model_inst.xfer({1'b0, a}, 8'h00, x);
		chk(x & m, e);
	endtask : rdchk

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle

	// modem delivers a payload then the packet end; the answer must be ack or nack as the crc says
	task automatic send_pkt(input logic [4:0] lm1, input logic [7:0] base, input logic ok);
		logic seen, nk;
		seen = 1'b0;
		nk = 1'b0;
		for (int i = 0; i <= lm1; i++) begin
			@(posedge sys_clk);
			rf_byte_valid <= 1'b1;
			rf_byte <= base + 8'(i);
			@(posedge sys_clk);
			rf_byte_valid <= 1'b0;
		end
		@(posedge sys_clk);
		rf_pkt_done <= 1'b1;
		rf_pkt_len_m1 <= lm1;
		rf_pkt_crc_ok <= ok;
		for (int k = 0; k < 5; k++) begin
			@(posedge sys_clk);
			rf_pkt_done <= 1'b0;
			#1;
			if (ack_req === 1'b1) begin
				seen = 1'b1;
				nk = ack_nack;
			end
		end
		chk(8'(seen), 8'h01);
		chk(8'(nk), 8'(!ok));
		chk(8'(rf_tx_on), 8'h01);
		@(posedge sys_clk);
		rf_ack_sent <= 1'b1;
		@(posedge sys_clk);
		rf_ack_sent <= 1'b0;
		settle(3);
	endtask : send_pkt

	// one supply comparison; expectation from the level table and the chosen node
	task automatic mon(input logic [1:0] s, input logic [2:0] l, input logic f);
		logic [11:0] mv;
		logic res;
		mv = (s == 2'd0) ? core_mv : ((s == 2'd1) ? rail2_mv : batt_mv);
		res = (int'(mv) < LVL_MV[l]);
		wr(rfm_pkg::ADDR_MON, {1'b0, 1'b1, f, l, s});
		settle(600);
		rdchk(rfm_pkg::ADDR_STS1, 8'h04, {5'h00, (!f || res), 2'h0});
		rdchk(rfm_pkg::ADDR_MON, 8'h80, {res, 7'h00});
		wr(rfm_pkg::ADDR_STS1, 8'h04);
	endtask : mon

	// main sequence
	initial begin
		reset_n = 1'b0;
		{rf_pkt_done, rf_pkt_crc_ok, rf_byte_valid, rf_ack_sent, ev} = '0;
		rf_pkt_addr_match = 1'b1;
		rf_pkt_len_m1 = 5'h00;
		rf_byte = 8'h00;
		rf_burst_power = 4'hB;
		rf_avg_power = 4'h9;
		core_mv = 12'd1000;
		rail2_mv = 12'd2000;
		batt_mv = 12'd1200;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		settle(4);
		chk(8'(spi_miso_oe), 8'h00);
		rdchk(rfm_pkg::ADDR_STS1, 8'hFF, 8'h00);
		rdchk(rfm_pkg::ADDR_STS2, 8'hFF, 8'h00);
		rdchk(rfm_pkg::ADDR_MSK1, 8'hFF, 8'h00);
		rdchk(7'h20, 8'hFF, 8'h00);
		chk(vco_bias_trim, 8'h76);
		$display("test reset done");
		// all six event pulses at once, then mask and polarity steering of the pin
		@(posedge sys_clk);
		ev <= 6'h3F;
		@(posedge sys_clk);
		ev <= 6'h00;
		rdchk(rfm_pkg::ADDR_STS1, 8'hFF, 8'h72);
		rdchk(rfm_pkg::ADDR_STS2, 8'hFF, 8'h03);
		rdchk(rfm_pkg::ADDR_STS1, 8'hFF, 8'h72);
		chk(8'(irq_pin), 8'h00);
		wr(rfm_pkg::ADDR_MSK1, 8'h02);
		chk(8'(irq_pin), 8'h01);
		wr(rfm_pkg::ADDR_CFG, 8'h81);
		chk(8'(irq_pin), 8'h00);
		wr(rfm_pkg::ADDR_MSK1, 8'h00);
		chk(8'(irq_pin), 8'h01);
		wr(rfm_pkg::ADDR_CFG, 8'h01);
		wr(rfm_pkg::ADDR_STS1, 8'hFF);
		wr(rfm_pkg::ADDR_STS2, 8'h03);
		rdchk(rfm_pkg::ADDR_STS1, 8'hFF, 8'h00);
		rdchk(rfm_pkg::ADDR_STS2, 8'hFF, 8'h00);
		$display("test status done");
		// reception with auto-ack, burst power capture and a full fifo
		wr(rfm_pkg::ADDR_CHAN, 8'd39);
		chk(8'(rf_channel), 8'd39);
		wr(rfm_pkg::ADDR_ACK, 8'h00);
		wr(rfm_pkg::ADDR_SIG, 8'h20);
		wr(rfm_pkg::ADDR_MSK1, 8'h80);
		wr(rfm_pkg::ADDR_CFG, 8'h02);
		chk(8'(rf_rx_on), 8'h01);
		send_pkt(5'd2, 8'hA0, 1'b1);
		chk(8'(irq_pin), 8'h01);
		rdchk(rfm_pkg::ADDR_RXLEN, 8'h1F, 8'h02);
		for (int i = 0; i < 3; i++) begin
			rdchk(rfm_pkg::ADDR_RXWIN, 8'hFF, 8'hA0 + 8'(i));
		end
		rdchk(rfm_pkg::ADDR_SIG, 8'hFF, 8'h2B);
		wr(rfm_pkg::ADDR_STS1, 8'h80);
		chk(8'(irq_pin), 8'h00);
		wr(rfm_pkg::ADDR_FIFO, 8'h01);
		send_pkt(5'd0, 8'h00, 1'b0);
		rdchk(rfm_pkg::ADDR_STS1, 8'h80, 8'h00);
		send_pkt(5'd1, 8'hC0, 1'b1);
		send_pkt(5'd1, 8'hD0, 1'b1);
		chk(8'(rf_rx_on), 8'h00);
		wr(rfm_pkg::ADDR_FIFO, 8'h01);
		chk(8'(rf_rx_on), 8'h01);
		wr(rfm_pkg::ADDR_CFG, 8'h01);
		chk(8'(rf_rx_on), 8'h00);
		wr(rfm_pkg::ADDR_STS1, 8'hFF);
		$display("test receive done");
		// average power one-shot
		wr(rfm_pkg::ADDR_PAGE, 8'h00);
		wr(7'h1B, 8'hB4);
		wr(7'h1B, 8'h5D);
		wr(rfm_pkg::ADDR_SIG, 8'h10);
		wr(rfm_pkg::ADDR_TRIG, 8'h80);
		settle(3100);
		rdchk(rfm_pkg::ADDR_SIG, 8'hFF, 8'h19);
		wr(rfm_pkg::ADDR_SIG, 8'h00);
		wr(rfm_pkg::ADDR_TRIG, 8'h00);
		$display("test strength done");
		// supply monitor: every node, every level, both flag modes
		for (int s = 0; s < 3; s++) begin
			mon(2'(s), 3'd3, 1'b0);
		end
		for (int l = 0; l < 8; l++) begin
			mon(2'd1, 3'(l), 1'b0);
		end
		mon(2'd1, 3'd3, 1'b1);
		mon(2'd0, 3'd3, 1'b1);
		$display("test monitor done");
		// leaving deep sleep
		wr(rfm_pkg::ADDR_PWR, 8'h02);
		chk(8'(deep_sleep), 8'h01);
		wr(rfm_pkg::ADDR_PWR, 8'h00);
		settle(300);
		rdchk(rfm_pkg::ADDR_STS1, 8'h01, 8'h01);
		wr(rfm_pkg::ADDR_STS1, 8'h01);
		$display("test sleep done");
		// trim is reachable only behind the test page
		wr(rfm_pkg::ADDR_PAGE, 8'h01);
		wr(rfm_pkg::ADDR_VCO, 8'h66);
		wr(rfm_pkg::ADDR_PAGE, 8'h00);
		chk(vco_bias_trim, 8'h66);
		wr(rfm_pkg::ADDR_VCO, 8'h76);
		chk(vco_bias_trim, 8'h66);
		wr(rfm_pkg::ADDR_PAGE, 8'h01);
		wr(rfm_pkg::ADDR_VCO, 8'h76);
		wr(rfm_pkg::ADDR_PAGE, 8'h00);
		chk(vco_bias_trim, 8'h76);
		$display("test trim done");
		results();
	end
endmodule : rx_flow_monitor_irq_control_tb
`default_nettype wire
